// file: dpc_top.sv
// Top of the dual synthesizer control logic: latches, modes, power-down.
// Assumes analog loop status and divider ticks arrive on clk.
//
// Contract
// - Single-side lock mode: mux pin high when locked, low pulses only.
// - Dual lock mode: locked shown only while both loops lock.
// - IF reset mode: IF counters held reset, IF pump three-stated.
// - Main reset mode: main counters held reset, main pump three-stated.
// - Combined reset mode resets both sides' counters together.
// - After reset release AB counter restarts aligned with reference counter.
// - Fast lock active with main gain bit; mux pin grounds damping resistor.
// - IF power-down with pump enabled: three-state pump, then power down.
// - IF power-down with pump three-stated: power down at strobe edge.
// - Main power-down with pump enabled: three-state pump, then power down.
// - Main power-down with pump three-stated: power down at strobe edge.
// - Power-down loads dividers and puts RF input in high impedance.
// - Reference oscillator off only while both power-down bits set.
// - Shift register and latches keep working in every power-down.
// - Latching a zero power-down bit restores the side at once.
// - Select 00 loads the IF reference latch.
// - Select 01 loads the IF AB latch, A and B counts.
// - Select 10 loads the main reference latch.
// - Select 11 loads the main AB latch, A and B counts.
// - Three-state bit one turns the pump off, zero runs it.
// - Fast lock gives maximum pump current; clearing gain bit ends it.
// - Host shifts 22 bits on serial clock rise; strobe rise latches.
`timescale 1ns/1ns
`default_nettype none
module dpc_top (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   nrst,
    // Serial link pins
    input  wire logic                   serial_clk,
    input  wire logic                   serial_data,
    input  wire logic                   latch_load_strobe,
    // Loop status from each side
    input  wire dpc_pkg::dpc_loop_in_t  if_loop_in,
    input  wire dpc_pkg::dpc_loop_in_t  main_loop_in,
    // Mux output pin
    output logic                        mux_output_pin,
    // Side controls
    output dpc_pkg::dpc_side_out_t      if_side_out,
    output dpc_pkg::dpc_side_out_t      main_side_out,
    // Global
    output logic                        ref_osc_disable,
    output logic                        outputs_active
);

    // ------------------------------------------------------------
    // Serial input
    // ------------------------------------------------------------
    logic [dpc_pkg::WORD_W-1:0] word;
    logic                       load;

    dpc_serial_rx u_rx (
        .clk               (clk),
        .nrst              (nrst),
        .serial_clk        (serial_clk),
        .serial_data       (serial_data),
        .latch_load_strobe (latch_load_strobe),
        .word_q            (word),
        .load_q            (load)
    );

    // ------------------------------------------------------------
    // Latch select decode
    // ------------------------------------------------------------
    wire [1:0] sel = word[dpc_pkg::SEL_LSB +: 2];

    wire ld_if_ref   = load && (sel == dpc_pkg::SEL_IF_REF);
    wire ld_if_ab    = load && (sel == dpc_pkg::SEL_IF_AB);
    wire ld_main_ref = load && (sel == dpc_pkg::SEL_MAIN_REF);
    wire ld_main_ab  = load && (sel == dpc_pkg::SEL_MAIN_AB);

    // ------------------------------------------------------------
    // Latches
    // ------------------------------------------------------------
    logic [dpc_pkg::WORD_W-1:0] if_ref_q;
    logic [dpc_pkg::WORD_W-1:0] if_ab_q;
    logic [dpc_pkg::WORD_W-1:0] main_ref_q;
    logic [dpc_pkg::WORD_W-1:0] main_ab_q;
    logic [3:0]                 written_q;

    // Each latch changes only on its own strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            if_ref_q   <= dpc_pkg::LATCH_RST;
            if_ab_q    <= dpc_pkg::LATCH_RST;
            main_ref_q <= dpc_pkg::LATCH_RST;
            main_ab_q  <= dpc_pkg::LATCH_RST;
        end else begin
            if (ld_if_ref) begin
                if_ref_q <= word;
            end
            if (ld_if_ab) begin
                if_ab_q <= word;
            end
            if (ld_main_ref) begin
                main_ref_q <= word;
            end
            if (ld_main_ab) begin
                main_ab_q <= word;
            end
        end
    end

    // No reset pin on the part: dividers stay in load and outputs_active low until every latch was set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            written_q <= 4'h0;
        end else begin
            written_q <= written_q | {ld_main_ab, ld_main_ref, ld_if_ab, ld_if_ref};
        end
    end

    wire all_written = (written_q == dpc_pkg::WRITTEN_ALL);

    // ------------------------------------------------------------
    // Latch fields
    // ------------------------------------------------------------
    wire if_tri_bit     = if_ref_q[dpc_pkg::TRI_BIT];
    wire main_tri_bit   = main_ref_q[dpc_pkg::TRI_BIT];
    wire if_gain_bit    = if_ref_q[dpc_pkg::GAIN_BIT];
    wire main_gain_bit  = main_ref_q[dpc_pkg::GAIN_BIT];
    wire if_pol_bit     = if_ref_q[dpc_pkg::POL_BIT];
    wire main_pol_bit   = main_ref_q[dpc_pkg::POL_BIT];
    wire if_pre_bit     = if_ab_q[dpc_pkg::PRE_BIT];
    wire main_pre_bit   = main_ab_q[dpc_pkg::PRE_BIT];
    wire if_pd_bit      = if_ab_q[dpc_pkg::PD_BIT];
    wire main_pd_bit    = main_ab_q[dpc_pkg::PD_BIT];

    wire [3:0] mux_mode = {main_ref_q[dpc_pkg::MUXHI_BIT],
                           main_ref_q[dpc_pkg::MUXLO_BIT],
                           if_ref_q[dpc_pkg::MUXHI_BIT],
                           if_ref_q[dpc_pkg::MUXLO_BIT]};

    // ------------------------------------------------------------
    // Counter reset modes
    // ------------------------------------------------------------
    wire rst_both = (mux_mode == dpc_pkg::MUX_RST_BOTH);
    wire rst_if   = (mux_mode == dpc_pkg::MUX_RST_IF);
    wire rst_main = (mux_mode == dpc_pkg::MUX_RST_MAIN);

    // One signal resets R and AB together, so both restart on the same edge
    wire if_cnt_rst   = rst_if | rst_both;
    wire main_cnt_rst = rst_main | rst_both;

    // ------------------------------------------------------------
    // Power-down sequencers
    // ------------------------------------------------------------
    logic if_cp_off;
    logic if_down;
    logic main_cp_off;
    logic main_down;
    logic if_ref_prev_q;
    logic main_ref_prev_q;

    // Safe point for the synchronous case is a reference divider edge
    wire if_ref_tick   = if_loop_in.ref_div & ~if_ref_prev_q;
    wire main_ref_tick = main_loop_in.ref_div & ~main_ref_prev_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            if_ref_prev_q   <= 1'b0;
            main_ref_prev_q <= 1'b0;
        end else begin
            if_ref_prev_q   <= if_loop_in.ref_div;
            main_ref_prev_q <= main_loop_in.ref_div;
        end
    end

    // Power-down bit is taken from the incoming word, mode bit from its latch
    dpc_side_ctrl u_if_pd (
        .clk          (clk),
        .nrst         (nrst),
        .ab_load      (ld_if_ab),
        .pd_bit       (word[dpc_pkg::PD_BIT]),
        .tri_bit      (if_tri_bit),
        .ref_tick     (if_ref_tick),
        .cp_off       (if_cp_off),
        .powered_down (if_down)
    );

    dpc_side_ctrl u_main_pd (
        .clk          (clk),
        .nrst         (nrst),
        .ab_load      (ld_main_ab),
        .pd_bit       (word[dpc_pkg::PD_BIT]),
        .tri_bit      (main_tri_bit),
        .ref_tick     (main_ref_tick),
        .cp_off       (main_cp_off),
        .powered_down (main_down)
    );

    // ------------------------------------------------------------
    // Fast lock
    // ------------------------------------------------------------
    wire fast_lock = main_gain_bit;

    // ------------------------------------------------------------
    // Side outputs
    // ------------------------------------------------------------
    dpc_pkg::dpc_side_out_t if_d;
    dpc_pkg::dpc_side_out_t main_d;
    dpc_pkg::dpc_side_out_t if_q;
    dpc_pkg::dpc_side_out_t main_q;

    always_comb begin
        if_d.r_count        = if_ref_q[dpc_pkg::R_LSB +: dpc_pkg::R_W];
        if_d.b_count        = if_ab_q[dpc_pkg::B_LSB +: dpc_pkg::B_W];
        if_d.a_count        = if_ab_q[dpc_pkg::A_LSB +: dpc_pkg::A_W];
        if_d.prescaler_sel  = if_pre_bit;
        if_d.pd_polarity    = if_pol_bit;
        if_d.cp_gain        = if_gain_bit;
        if_d.cp_current_max = 1'b0;
        if_d.cp_tristate    = if_tri_bit | rst_if | if_cp_off;
        if_d.counter_reset  = if_cnt_rst;
        if_d.divider_load   = if_down | ~all_written;
        if_d.rf_input_hiz   = if_down;
        if_d.powered_down   = if_down;
    end

    always_comb begin
        main_d.r_count        = main_ref_q[dpc_pkg::R_LSB +: dpc_pkg::R_W];
        main_d.b_count        = main_ab_q[dpc_pkg::B_LSB +: dpc_pkg::B_W];
        main_d.a_count        = main_ab_q[dpc_pkg::A_LSB +: dpc_pkg::A_W];
        main_d.prescaler_sel  = main_pre_bit;
        main_d.pd_polarity    = main_pol_bit;
        main_d.cp_gain        = main_gain_bit;
        main_d.cp_current_max = fast_lock;
        main_d.cp_tristate    = main_tri_bit | rst_main | main_cp_off;
        main_d.counter_reset  = main_cnt_rst;
        main_d.divider_load   = main_down | ~all_written;
        main_d.rf_input_hiz   = main_down;
        main_d.powered_down   = main_down;
    end

    // ------------------------------------------------------------
    // Mux output selection
    // ------------------------------------------------------------
    // Narrow low pulses come from phase detector activity while locked
    wire if_ald   = if_loop_in.locked & ~if_loop_in.pd_pulse;
    wire main_ald = main_loop_in.locked & ~main_loop_in.pd_pulse;
    wire both_ald = if_ald & main_ald;

    logic mux_d;
    logic mux_q;

    always_comb begin
        case (mux_mode)
            dpc_pkg::MUX_IF_ALD:   mux_d = if_ald;
            dpc_pkg::MUX_IF_REF:   mux_d = if_loop_in.ref_div;
            dpc_pkg::MUX_IF_N:     mux_d = if_loop_in.n_div;
            dpc_pkg::MUX_MAIN_ALD: mux_d = main_ald;
            dpc_pkg::MUX_BOTH_ALD: mux_d = both_ald;
            dpc_pkg::MUX_MAIN_REF: mux_d = main_loop_in.ref_div;
            dpc_pkg::MUX_MAIN_N:   mux_d = main_loop_in.n_div;
            // Low closes the switch that grounds the damping resistor
            dpc_pkg::MUX_FASTLOCK: mux_d = ~fast_lock;
            default:               mux_d = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic osc_off_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            if_q      <= '0;
            main_q    <= '0;
            mux_q     <= 1'b0;
            osc_off_q <= 1'b0;
        end else begin
            if_q      <= if_d;
            main_q    <= main_d;
            mux_q     <= mux_d;
            osc_off_q <= if_pd_bit & main_pd_bit;
        end
    end

    assign if_side_out     = if_q;
    assign main_side_out   = main_q;
    assign mux_output_pin  = mux_q;
    assign ref_osc_disable = osc_off_q;
    assign outputs_active  = all_written;

endmodule
`default_nettype wire

// file: dpc_pkg.sv
// Shared constants and types of the dual synthesizer control block.
// Assumes one system clock; all fields sit in a 22-bit serial word.
package dpc_pkg;

    // ------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------
    localparam int WORD_W    = 22;
    localparam int SEL_LSB   = 0;
    localparam int R_LSB     = 2;
    localparam int R_W       = 14;
    localparam int POL_BIT   = 17;
    localparam int GAIN_BIT  = 18;
    localparam int TRI_BIT   = 19;
    localparam int MUXLO_BIT = 20;
    localparam int MUXHI_BIT = 21;
    localparam int A_LSB     = 2;
    localparam int A_W       = 6;
    localparam int B_LSB     = 9;
    localparam int B_W       = 11;
    localparam int PRE_BIT   = 20;
    localparam int PD_BIT    = 21;

    // ------------------------------------------------------------
    // Latch select codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_IF_REF   = 2'h0;
    localparam logic [1:0] SEL_IF_AB    = 2'h1;
    localparam logic [1:0] SEL_MAIN_REF = 2'h2;
    localparam logic [1:0] SEL_MAIN_AB  = 2'h3;
    localparam logic [WORD_W-1:0] LATCH_RST = 22'h000000;
    localparam logic [3:0] WRITTEN_ALL  = 4'hF;

    // ------------------------------------------------------------
    // Mux output modes: {main hi, main lo, if hi, if lo}
    // ------------------------------------------------------------
    localparam logic [3:0] MUX_LOW       = 4'h0;
    localparam logic [3:0] MUX_IF_ALD    = 4'h1;
    localparam logic [3:0] MUX_IF_REF    = 4'h2;
    localparam logic [3:0] MUX_IF_N      = 4'h3;
    localparam logic [3:0] MUX_MAIN_ALD  = 4'h4;
    localparam logic [3:0] MUX_BOTH_ALD  = 4'h5;
    localparam logic [3:0] MUX_MAIN_REF  = 4'h6;
    localparam logic [3:0] MUX_MAIN_N    = 4'h7;
    localparam logic [3:0] MUX_FASTLOCK  = 4'h8;
    localparam logic [3:0] MUX_RST_IF    = 4'h9;
    localparam logic [3:0] MUX_RST_BOTH  = 4'hA;
    localparam logic [3:0] MUX_RST_MAIN  = 4'hB;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {PD_RUN, PD_DRAIN, PD_DOWN} dpc_pd_state_t;

    typedef struct packed {
        logic locked;
        logic pd_pulse;
        logic ref_div;
        logic n_div;
    } dpc_loop_in_t;

    typedef struct packed {
        logic [R_W-1:0] r_count;
        logic [B_W-1:0] b_count;
        logic [A_W-1:0] a_count;
        logic           prescaler_sel;
        logic           pd_polarity;
        logic           cp_gain;
        logic           cp_current_max;
        logic           cp_tristate;
        logic           counter_reset;
        logic           divider_load;
        logic           rf_input_hiz;
        logic           powered_down;
    } dpc_side_out_t;

endpackage

// file: dpc_serial_rx.sv
// Serial input register: samples the three link pins on clk.
// Assumes the link clock is several clk periods long.
`timescale 1ns/1ns
`default_nettype none
module dpc_serial_rx (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       nrst,
    // Link pins
    input  wire logic                       serial_clk,
    input  wire logic                       serial_data,
    input  wire logic                       latch_load_strobe,
    // Received word
    output logic [dpc_pkg::WORD_W-1:0]      word_q,
    output logic                            load_q
);
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [1:0] prev_q;
    logic [dpc_pkg::WORD_W-1:0] shift_q;
    wire        clk_rise = sync2_q[0] & ~prev_q[0];
    wire        le_rise  = sync2_q[2] & ~prev_q[1];

    // Data goes through the same two stages, so it stays aligned with its clock edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q  <= 2'h0;
        end else begin
            sync1_q <= {latch_load_strobe, serial_data, serial_clk};
            sync2_q <= sync1_q;
            prev_q  <= {sync2_q[2], sync2_q[0]};
        end
    end

    // Shifting never stops, whatever the power state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_q <= dpc_pkg::LATCH_RST;
            word_q  <= dpc_pkg::LATCH_RST;
            load_q  <= 1'b0;
        end else begin
            if (clk_rise) begin
                shift_q <= {shift_q[dpc_pkg::WORD_W-2:0], sync2_q[1]};
            end
            if (le_rise) begin
                word_q <= shift_q;
            end
            load_q <= le_rise;
        end
    end
endmodule
`default_nettype wire

// file: dpc_side_ctrl.sv
// Power-down sequencer of one synthesizer side.
// Assumes ref_tick is a one-cycle pulse per reference divider period.
`timescale 1ns/1ns
`default_nettype none
module dpc_side_ctrl (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Latch events
    input  wire logic ab_load,
    input  wire logic pd_bit,
    input  wire logic tri_bit,
    input  wire logic ref_tick,
    // State
    output logic      cp_off,
    output logic      powered_down
);
    dpc_pkg::dpc_pd_state_t state_q;
    dpc_pkg::dpc_pd_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            dpc_pkg::PD_RUN: begin
                if (ab_load && pd_bit) begin
                    // Pump already off: no need to wait for a safe edge
                    state_d = tri_bit ? dpc_pkg::PD_DOWN : dpc_pkg::PD_DRAIN;
                end
            end
            dpc_pkg::PD_DRAIN: begin
                if (ab_load && !pd_bit) begin
                    state_d = dpc_pkg::PD_RUN;
                end else if (ref_tick) begin
                    state_d = dpc_pkg::PD_DOWN;
                end
            end
            default: begin
                if (ab_load && !pd_bit) begin
                    state_d = dpc_pkg::PD_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= dpc_pkg::PD_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    assign cp_off       = (state_q != dpc_pkg::PD_RUN);
    assign powered_down = (state_q == dpc_pkg::PD_DOWN);
endmodule
`default_nettype wire

// file: dpc_monitor.sv
// Port checker of dpc_top: pump, power-down and latch timing relations.
// Assumes one clk domain; bound to every dpc_top at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module dpc_monitor (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   nrst,
    // Watched ports
    input wire logic                   latch_load_strobe,
    input wire dpc_pkg::dpc_side_out_t if_side_out,
    input wire dpc_pkg::dpc_side_out_t main_side_out,
    input wire logic                   ref_osc_disable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Cycles since the strobe pin rose, saturating so old writes age out
    logic [3:0] since_q;
    logic [3:0] since_d;
    logic       le_q;
    assign since_d = (latch_load_strobe && !le_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hF};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            since_q <= 4'hF;
            le_q    <= 1'b0;
        end else begin
            since_q <= since_d;
            le_q    <= latch_load_strobe;
        end
    end

    sequence s_if_down;
        $rose(if_side_out.powered_down);
    endsequence
    sequence s_main_down;
        $rose(main_side_out.powered_down);
    endsequence

    a_if_pump_first: assert property (s_if_down |-> $past(if_side_out.cp_tristate))
        else $error("IF side powered down with its pump still driving");
    a_main_pump_first: assert property (s_main_down |-> $past(main_side_out.cp_tristate))
        else $error("main side powered down with its pump still driving");
    a_if_down_hiz: assert property (if_side_out.powered_down |-> if_side_out.rf_input_hiz && if_side_out.divider_load)
        else $error("IF side down without divider load or input off");
    a_main_down_hiz: assert property (main_side_out.powered_down |-> main_side_out.rf_input_hiz && main_side_out.divider_load)
        else $error("main side down without divider load or input off");
    a_osc_both_down: assert property ((if_side_out.powered_down && main_side_out.powered_down) [*2] |-> ref_osc_disable)
        else $error("oscillator still on with both sides down");
    a_fast_max_gain: assert property (main_side_out.cp_current_max == main_side_out.cp_gain)
        else $error("pump current maximum does not follow the gain bit");
    a_if_reset_pump: assert property (if_side_out.counter_reset && !main_side_out.counter_reset |-> if_side_out.cp_tristate)
        else $error("IF counter reset with IF pump driving");
    a_main_reset_pump: assert property (main_side_out.counter_reset && !if_side_out.counter_reset |-> main_side_out.cp_tristate)
        else $error("main counter reset with main pump driving");
    a_only_at_strobe: assert property ($changed(if_side_out.r_count) || $changed(main_side_out.r_count) |-> since_q <= 4'h8)
        else $error("reference count changed without a strobe");
endmodule

bind dpc_top dpc_monitor u_mon (
    .clk              (clk),
    .nrst             (nrst),
    .latch_load_strobe(latch_load_strobe),
    .if_side_out      (if_side_out),
    .main_side_out    (main_side_out),
    .ref_osc_disable  (ref_osc_disable)
);
`default_nettype wire

// file: dpc_host.sv
// Host model of the three-wire link: shifts one word, then strobes it in.
// Assumes the bench calls send; the link clock stands still between words.
`timescale 1ns/1ns
`default_nettype none
module dpc_host (
    // Clock
    input  wire logic clk,
    // Link pins
    output logic      serial_clk,
    output logic      serial_data,
    output logic      latch_load_strobe
);
    initial begin
        serial_clk        = 1'b0;
        serial_data       = 1'b0;
        latch_load_strobe = 1'b0;
    end
    // Four clk low, four high: a 320 ns link clock, data held well past each rise
    task automatic send(input logic [21:0] w);
        for (int i = 21; i >= 0; i--) begin
            @(posedge clk);
            serial_clk  <= 1'b0;
            serial_data <= w[i];
            repeat (4) @(posedge clk);
            serial_clk <= 1'b1;
            repeat (3) @(posedge clk);
        end
        @(posedge clk);
        serial_clk <= 1'b0;
        // Released data line shows the inverse, so a stale bit cannot pass
        serial_data <= ~w[0];
        repeat (2) @(posedge clk);
        latch_load_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        latch_load_strobe <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb_dpc_top.sv
// Self-checking bench of dpc_top: host model writes, queued notes compared.
// Assumes dpc_host drives the link; loop status is driven from here.
`timescale 1ns/1ns
`default_nettype none
module tb_dpc_top;
    typedef struct packed {
        dpc_pkg::dpc_side_out_t i, m;
        logic mux, osc, act, use_mux;
    } dpc_note_t;

    logic                   clk = 1'b0, nrst = 1'b0, tog = 1'b0;
    logic                   sck, sd, le, mux, osc, act;
    logic [31:0]            seed = 32'h00007B76;
    logic [21:0]            ir = '0, ia = '0, mr = '0, ma = '0;
    logic [3:0]             wrote = 4'h0;
    dpc_pkg::dpc_loop_in_t  li = '0, lm = '0;
    dpc_pkg::dpc_side_out_t io, mo;
    dpc_note_t              q[$];
    int                     bad_count = 0, tests_run = 0;
    event                   settle;
    // Bring-up, async down, wake, then sync down: {select, tristate or power-down bit}
    logic [2:0] plan [17] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1, 3'h3, 3'h5, 3'h7, 3'h1, 3'h2,
                              3'h6, 3'h0, 3'h4, 3'h3, 3'h7, 3'h2, 3'h6};

    dpc_host h (.clk(clk), .serial_clk(sck), .serial_data(sd), .latch_load_strobe(le));
    dpc_top dut (.clk(clk), .nrst(nrst), .serial_clk(sck), .serial_data(sd),
        .latch_load_strobe(le), .if_loop_in(li), .main_loop_in(lm), .mux_output_pin(mux),
        .if_side_out(io), .main_side_out(mo), .ref_osc_disable(osc), .outputs_active(act));

    initial forever #20 clk = ~clk;
    // Divider edges keep coming so a synchronous power-down can complete
    always @(posedge clk) if (tog) begin
        li.ref_div <= ~li.ref_div;
        lm.ref_div <= ~lm.ref_div;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [19:0] fld(logic [1:0] sel, logic b, logic [1:0] md);
        logic [31:0] r;
        r = rnd();
        if (sel[0])
            return {b, r[18:0]} & 20'hFFFBF;
        return {md, b, r[17:16], 1'b0, r[13:0]};
    endfunction
    function automatic dpc_pkg::dpc_side_out_t side(logic [21:0] r, logic [21:0] ab,
            logic rs, logic rb, logic mn);
        return {r[15:2], ab[19:9], ab[7:2], ab[20], r[17], r[18], mn & r[18],
                r[19] | ab[21] | rs, rs | rb, ab[21] | (wrote != 4'hF), ab[21], ab[21]};
    endfunction
    function automatic logic muxe(logic [3:0] md);
        logic a, b;
        a = li.locked & ~li.pd_pulse;
        b = lm.locked & ~lm.pd_pulse;
        case (md)
            4'h1: return a;
            4'h2: return li.ref_div;
            4'h3: return li.n_div;
            4'h4: return b;
            4'h5: return a & b;
            4'h6: return lm.ref_div;
            4'h7: return lm.n_div;
            4'h8: return ~mr[18];
            default: return 1'b0;
        endcase
    endfunction

    task automatic wr(input logic [1:0] sel, input logic [19:0] f);
        logic [31:0] r;
        logic [3:0]  md;
        dpc_note_t   n;
        r = rnd();
        @(posedge clk);
        if (!tog) begin
            li <= r[3:0];
            lm <= r[7:4];
        end
        case (sel)
            2'h0: ir = {f, sel};
            2'h1: ia = {f, sel};
            2'h2: mr = {f, sel};
            default: ma = {f, sel};
        endcase
        wrote[sel] = 1'b1;
        h.send({f, sel});
        md = {mr[21:20], ir[21:20]};
        n.i = side(ir, ia, md == 4'h9, md == 4'hA, 1'b0);
        n.m = side(mr, ma, md == 4'hB, md == 4'hA, 1'b1);
        n.mux = muxe(md);
        n.osc = ia[21] & ma[21];
        n.act = wrote == 4'hF;
        n.use_mux = !tog || md == 4'h0;
        q.push_back(n);
        repeat (40) @(posedge clk);
        -> settle;
    endtask

    task automatic chk_side(string s, dpc_pkg::dpc_side_out_t e, dpc_pkg::dpc_side_out_t g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk_bit(string s, logic e, logic g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", s, e, g);
        end
    endtask

    initial begin
        dpc_note_t n;
        forever begin
            @settle;
            @(negedge clk);
            n = q.pop_front();
            chk_side("if side", n.i, io);
            chk_side("main side", n.m, mo);
            chk_bit("osc off", n.osc, osc);
            chk_bit("outputs on", n.act, act);
            if (n.use_mux)
                chk_bit("mux pin", n.mux, mux);
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #2000000;
        bad_count++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 17; i++) begin
            if (i == 11) begin
                @(negedge clk);
                tog = 1'b1;
            end
            wr(plan[i][2:1], fld(plan[i][2:1], plan[i][0], 2'h0));
        end
        @(negedge clk);
        tog = 1'b0;
        for (int m = 0; m < 16; m++) begin
            wr(2'h0, fld(2'h0, 1'b0, m[1:0]));
            wr(2'h2, fld(2'h2, 1'b0, m[3:2]));
        end
        repeat (2) @(posedge clk);
        end_of_test();
    end
endmodule
`default_nettype wire
